// >>> pkg/mid_pkg.sv
// package: encodings, register map and types for the instruction decoder
package mid_pkg;
  // ****************************************
  // instruction word fields
  // ****************************************
  localparam int INSTR_W = 16;
  localparam int TARGET_W = 20;
  localparam int REL_W = 11;
  localparam int PTR_W = 12;
  // top nibble prefixes
  localparam logic [3:0] PFX_LIT = 4'h0;
  localparam logic [3:0] PFX_TGL = 4'h7;
  localparam logic [3:0] PFX_SET = 4'h8;
  localparam logic [3:0] PFX_CLR = 4'h9;
  localparam logic [3:0] PFX_TSS = 4'ha;
  localparam logic [3:0] PFX_TSC = 4'hb;
  localparam logic [3:0] PFX_REL = 4'hd;
  localparam logic [3:0] PFX_CTL = 4'he;
  localparam logic [3:0] PFX_W2 = 4'hf;
  // second nibble under the control prefix
  localparam logic [2:0] N2_CALL = 3'h6;
  localparam logic [3:0] N2_ABSOLUTE_JUMP_OP = 4'hf;
  localparam logic [3:0] N2_PTR = 4'he;
  localparam logic [1:0] PTR_PAD = 2'h0;
  // second nibble under the literal prefix
  localparam logic [3:0] N2_MISC = 4'h0;
  localparam logic [3:0] N2_BANK = 4'h1;
  localparam logic [3:0] N2_SUB = 4'h8;
  localparam logic [3:0] N2_IOR = 4'h9;
  localparam logic [3:0] N2_XOR = 4'ha;
  localparam logic [3:0] N2_AND = 4'hb;
  localparam logic [3:0] N2_RETLIT = 4'hc;
  localparam logic [3:0] N2_MUL = 4'hd;
  localparam logic [3:0] N2_MOVLIT = 4'he;
  localparam logic [3:0] N2_ADD = 4'hf;
  // low byte under the misc group
  localparam logic [7:0] LO_NOP = 8'h00;
  localparam logic [7:0] LO_SLEEP = 8'h03;
  localparam logic [7:0] LO_WDT = 8'h04;
  localparam logic [7:0] LO_PUSH = 8'h05;
  localparam logic [7:0] LO_POP = 8'h06;
  localparam logic [7:0] LO_DECADJ = 8'h07;
  localparam logic [7:0] LO_SWRST = 8'hff;
  localparam logic [6:0] LO_IRET = 7'h08;
  localparam logic [6:0] LO_RET = 7'h09;
  localparam logic [5:0] LO_TABLE_READ_OP = 6'h02;
  localparam logic [5:0] LO_TBLWR = 6'h03;
  // branch condition select
  localparam logic [1:0] CC_ZERO = 2'h0;
  localparam logic [1:0] CC_CARRY = 2'h1;
  localparam logic [1:0] CC_OVF = 2'h2;
  localparam logic [1:0] CC_NEG = 2'h3;
  // ****************************************
  // register map
  // ****************************************
  localparam int RA_W = 8;
  localparam int RD_W = 8;
  localparam logic [7:0] REG_CTL = 8'h00;
  localparam logic [7:0] REG_TMR_ADDR = 8'h01;
  localparam logic [7:0] REG_PORT_LO = 8'h02;
  localparam logic [7:0] REG_PORT_HI = 8'h03;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CTL_PSA = 0;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] TMR_ADDR_RST = 8'h80;
  localparam logic [7:0] PORT_LO_RST = 8'h80;
  localparam logic [7:0] PORT_HI_RST = 8'h84;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [4:0] {
    NOP_OP, BIT_CLEAR_OP, BIT_SET_OP, BIT_TOGGLE_OP,
    TEST_SKIP_CLEAR_OP, TEST_SKIP_SET_OP, BRANCH_COND_OP,
    BRANCH_ALWAYS_OP, RELATIVE_CALL_OP, ABS_CALL_OP,
    ABSOLUTE_JUMP_OP, STANDBY_OP, WATCHDOG_CLEAR_OP,
    DECIMAL_ADJUST_OP, STACK_PUSH_OP, STACK_POP_OP,
    INTERRUPT_RETURN_OP, SUB_RETURN_OP, LITERAL_RETURN_OP,
    ADD_LITERAL_OP, LITERAL_SUBTRACT_OP, AND_LITERAL_OP,
    OR_LITERAL_OP, XOR_LITERAL_OP, LITERAL_MOVE_OP,
    LITERAL_MULTIPLY_OP, BANK_SELECT_LOAD_OP, POINTER_LOAD_OP,
    TABLE_READ_OP, TABLE_WRITE_OP, SOFT_RESET_OP, BYTE_FILE_OP
  } mid_op_e;

  typedef enum logic [1:0] {ST_EXEC, ST_WORD2, ST_FLUSH} mid_state_e;

  typedef struct packed {
    logic carry;
    logic digit_carry;
    logic zero;
    logic overflow;
    logic negative;
  } mid_alu_s;

  typedef struct packed {
    mid_alu_s alu;
    logic timeout;
    logic powerdown;
  } mid_flags_s;

  typedef struct packed {
    mid_op_e op;
    logic [7:0] lit;
    logic [7:0] file;
    logic [2:0] bitsel;
    logic bank_acc;
    logic fast;
    logic [1:0] tbl_mode;
    logic [1:0] ptr_sel;
    logic [PTR_W-1:0] ptr_lit;
    logic [REL_W-1:0] rel;
    logic [TARGET_W-1:0] target;
    mid_flags_s flags;
  } mid_dec_s;
endpackage

// >>> verif/mcu_instruction_decoder_ctl_lit_tb_top.sv
// self-checking bench for the instruction decoder
`timescale 1ns/100ps
module mcu_instruction_decoder_ctl_lit_tb_top;
  import mid_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic go = 1'b0;
  logic [15:0] instr_i;
  logic instr_valid_i;
  mid_alu_s status_i = '0;
  logic file_bit_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [7:0] tst_file_o;
  logic [2:0] tst_bit_o;
  mid_dec_s dec_o;
  logic dec_valid_o, pc_load_o, skip_o, nop_cycle_o, prescaler_clr_o, pin_read_o;
  int fail_count = 0;
  int num_checks = 0;
  int seed = 24;
  mid_dec_s dq[$];
  logic [4:0] fq[$];
  logic [3:0] pf [5] = '{PFX_CLR, PFX_SET, PFX_TGL, PFX_TSC, PFX_TSS};
  mid_op_e ot [5] = '{BIT_CLEAR_OP, BIT_SET_OP, BIT_TOGGLE_OP, TEST_SKIP_CLEAR_OP,
    TEST_SKIP_SET_OP};
  always #10 mclk_i = ~mclk_i;
  mid_decoder mid_decoder_i (.mclk_i, .rst_i, .instr_i, .instr_valid_i, .status_i, .file_bit_i,
    .tst_file_o, .tst_bit_o, .dec_o, .dec_valid_o, .pc_load_o, .skip_o, .nop_cycle_o,
    .prescaler_clr_o, .pin_read_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o);
  mid_pmem mid_pmem_i (.mclk_i, .rst_i, .go_i(go), .instr_o(instr_i), .valid_o(instr_valid_i));
  // ****************************************
  // monitor, checks and bus tasks
  // ****************************************
  always @(posedge mclk_i) begin
    if (!rst_i && dec_valid_o === 1'b1) begin
      dq.push_back(dec_o);
      fq.push_back({pc_load_o, skip_o, nop_cycle_o, prescaler_clr_o, pin_read_o});
    end
  end
  task automatic end_of_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic c, input string m);
    num_checks++;
    if (c !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(posedge mclk_i);
    chk(reg_rdata_o === e, "register read");
  endtask
  task automatic prog(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    mid_pmem_i.mem[0] = a;
    mid_pmem_i.mem[1] = b;
    mid_pmem_i.mem[2] = c;
    mid_pmem_i.len = 3;
    dq.delete();
    fq.delete();
    go <= 1'b1;
    repeat (7) @(posedge mclk_i);
    go <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask
  task automatic one(input logic [15:0] w, input mid_op_e op, input logic [2:0] fl,
                     input logic tc);
    prog(w, 16'h0000, 16'h0000);
    chk(dq.size() == 3 && dq[0].op === op && fq[0][4:2] === fl, "decode");
    chk(fq[1][2] === tc, "second cycle");
  endtask
  function automatic void expect_op(input logic [15:0] w, output mid_op_e op,
                                    output logic pcl, output logic tc);
    pcl = 1'b0;
    tc = 1'b0;
    casez (w[11:0])
      12'h8??: op = LITERAL_SUBTRACT_OP;
      12'h9??: op = OR_LITERAL_OP;
      12'ha??: op = XOR_LITERAL_OP;
      12'hb??: op = AND_LITERAL_OP;
      12'hc??: op = LITERAL_RETURN_OP;
      12'hd??: op = LITERAL_MULTIPLY_OP;
      12'he??: op = LITERAL_MOVE_OP;
      12'hf??: op = ADD_LITERAL_OP;
      12'h10?: op = BANK_SELECT_LOAD_OP;
      12'h003: op = STANDBY_OP;
      12'h004: op = WATCHDOG_CLEAR_OP;
      12'h005: op = STACK_PUSH_OP;
      12'h006: op = STACK_POP_OP;
      12'h007: op = DECIMAL_ADJUST_OP;
      12'b0000_0000_1???: op = w[2] ? TABLE_WRITE_OP : TABLE_READ_OP;
      12'b0000_0001_000?: op = INTERRUPT_RETURN_OP;
      12'b0000_0001_001?: op = SUB_RETURN_OP;
      default: op = NOP_OP;
    endcase
    pcl = op inside {LITERAL_RETURN_OP, INTERRUPT_RETURN_OP, SUB_RETURN_OP};
    tc = pcl | (op inside {TABLE_READ_OP, TABLE_WRITE_OP});
  endfunction
  function automatic mid_flags_s exp_flags(input mid_op_e op);
    if (op inside {ADD_LITERAL_OP, LITERAL_SUBTRACT_OP}) return 7'h7c;
    if (op inside {AND_LITERAL_OP, OR_LITERAL_OP, XOR_LITERAL_OP}) return 7'h14;
    if (op inside {STANDBY_OP, WATCHDOG_CLEAR_OP}) return 7'h03;
    return (op == DECIMAL_ADJUST_OP) ? 7'h40 : 7'h00;
  endfunction
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [15:0] w, w1, w2;
    logic [7:0] k, t;
    mid_op_e op;
    logic pcl, tc, hit;
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    rd(REG_CTL, CTL_RST);
    rd(REG_TMR_ADDR, TMR_ADDR_RST);
    rd(REG_PORT_LO, PORT_LO_RST);
    rd(REG_PORT_HI, PORT_HI_RST);
    for (int i = 3; i < 36; i++) begin
      k = 8'($random(seed));
      w = (i < 20) ? {8'h00, 8'(i)} : (i < 28) ? {4'h0, 4'(i - 12), k} : {8'h01, 4'h0, k[3:0]};
      expect_op(w, op, pcl, tc);
      one(w, op, {pcl, 2'b00}, tc);
      chk(dq[0].flags === exp_flags(op), "flags");
      if (op inside {TABLE_READ_OP, TABLE_WRITE_OP})
        chk(dq[0].tbl_mode === w[1:0], "table mode");
      if (w[11:8] != 4'h0)
        chk(dq[0].lit === (w[11] ? w[7:0] : {4'h0, w[3:0]}), "lit");
      if (w[11:8] == 4'h0 && pcl) chk(dq[0].fast === w[0], "fast save");
    end
    for (int c = 0; c < 8; c++) begin
      k = 8'($random(seed));
      status_i <= mid_alu_s'($random(seed));
      @(posedge mclk_i);
      hit = (c / 2 == 0) ? status_i.zero : (c / 2 == 1) ? status_i.carry :
            (c / 2 == 2) ? status_i.overflow : status_i.negative;
      hit = hit ^ c[0];
      one({4'he, 1'b0, 3'(c), k}, BRANCH_COND_OP, {hit, 2'b00}, hit);
      chk(dq[0].rel === {{3{k[7]}}, k}, "branch offset");
    end
    w = 16'($random(seed));
    one({4'hd, 1'b0, w[10:0]}, BRANCH_ALWAYS_OP, 3'b100, 1'b1);
    one({4'hd, 1'b1, w[10:0]}, RELATIVE_CALL_OP, 3'b100, 1'b1);
    one({4'hf, w[11:0]}, NOP_OP, 3'b000, 1'b0);
    for (int j = 0; j < 3; j++) begin
      w = 16'($random(seed));
      k = 8'($random(seed));
      t = (j == 0) ? {7'h76, w[12]} : (j == 1) ? 8'hef : 8'hee;
      w1 = {t, (j == 2) ? {2'b00, k[5:0]} : k};
      w2 = {4'hf, w[11:0]};
      prog(w1, w2, 16'h0000);
      chk(dq.size() == 2 && fq[0][4:2] === {j != 2, 2'b00}, "pairing");
      if (j < 2) chk(dq[0].target === {w2[11:0], w1[7:0]} && (j > 0 || dq[0].fast === w1[8])
        && dq[0].op === (j == 0 ? ABS_CALL_OP : ABSOLUTE_JUMP_OP), "target");
      else chk(dq[0].op === POINTER_LOAD_OP && dq[0].ptr_lit === {w1[3:0], w2[7:0]}
        && dq[0].ptr_sel === w1[5:4], "pointer load");
    end
    t = {1'b1, 7'($random(seed))};
    wr(REG_CTL, 8'h01);
    wr(REG_TMR_ADDR, t);
    wr(REG_PORT_LO, 8'h10);
    wr(REG_PORT_HI, 8'h1f);
    wr(8'h07, 8'h5a);
    rd(REG_TMR_ADDR, t);
    rd(8'h07, 8'h00);
    for (int j = 0; j < 20; j++) begin
      k = (j % 4 == 0) ? t : (j % 4 == 1) ? 8'h10 : (j % 4 == 2) ? 8'h1f : 8'h20;
      w = 16'($random(seed));
      file_bit_i <= w[15];
      hit = (j / 4 == 3) ? !w[15] : (j / 4 == 4) ? w[15] : 1'b0;
      one({pf[j / 4], w[11:9], 1'b0, k}, ot[j / 4], {1'b0, hit, 1'b0}, hit);
      chk(fq[0][1:0] === {j < 12 && k == t, j < 12 && k inside {[8'h10:8'h1f]}}
        && dq[0].bitsel === w[11:9] && dq[0].file === k
        && dq[0].flags === 7'h00, "bit op side effects");
    end
    wr(REG_CTL, 8'h00);
    one({PFX_SET, 3'h2, 1'b0, t}, BIT_SET_OP, 3'b000, 1'b0);
    chk(fq[0][1] === 1'b0, "prescaler not assigned");
    wr(REG_STAT, 8'hff);
    rd(REG_STAT, 8'h00);
    end_of_test();
  end
endmodule

// >>> verif/mid_decoder_props.sv
// concurrent checks on the instruction decoder ports
`timescale 1ns/100ps
module mid_decoder_props (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // fetch and datapath
  input wire logic [mid_pkg::INSTR_W-1:0] instr_i,
  input wire logic instr_valid_i,
  input wire mid_pkg::mid_alu_s status_i,
  input wire logic file_bit_i,
  input wire logic [7:0] tst_file_o,
  input wire logic [2:0] tst_bit_o,
  // decoded command
  input wire mid_pkg::mid_dec_s dec_o,
  input wire logic dec_valid_o,
  input wire logic pc_load_o,
  input wire logic skip_o,
  input wire logic nop_cycle_o,
  input wire logic prescaler_clr_o,
  // register port
  input wire logic reg_rd_i,
  input wire logic [mid_pkg::RD_W-1:0] reg_rdata_o
);
  import mid_pkg::*;
  // ****************************************
  // branch condition of the word now fetched
  // ****************************************
  logic [3:0] cflag;
  logic br_hit;
  assign cflag = {status_i.negative, status_i.overflow, status_i.carry, status_i.zero};
  assign br_hit = cflag[instr_i[10:9]] ^ instr_i[8];
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  a_fields_follow: assert property (
    tst_file_o == instr_i[7:0] && tst_bit_o == instr_i[11:9])
    else $error("tested file or bit field wrong");
  a_skip_clear: assert property (
    dec_valid_o && dec_o.op == TEST_SKIP_CLEAR_OP |-> skip_o == !$past(file_bit_i))
    else $error("skip on clear wrong");
  a_skip_set: assert property (
    dec_valid_o && dec_o.op == TEST_SKIP_SET_OP |-> skip_o == $past(file_bit_i))
    else $error("skip on set wrong");
  a_branch_taken: assert property (
    dec_valid_o && dec_o.op == BRANCH_COND_OP |-> pc_load_o == $past(br_hit))
    else $error("branch decision wrong");
  a_call_target: assert property (
    dec_valid_o && dec_o.op inside {ABS_CALL_OP, ABSOLUTE_JUMP_OP}
    |-> pc_load_o && dec_o.target[19:8] == $past(instr_i[11:0]))
    else $error("two-word target wrong");
  a_flush_after_skip: assert property (skip_o && instr_valid_i |=> nop_cycle_o)
    else $error("word after skip not dropped");
  a_flush_after_jump: assert property (
    pc_load_o && instr_valid_i && !(dec_o.op inside {ABS_CALL_OP, ABSOLUTE_JUMP_OP})
    |=> nop_cycle_o)
    else $error("word after pc change not dropped");
  a_flush_is_nop: assert property (
    nop_cycle_o |-> dec_valid_o && dec_o.op == NOP_OP && !pc_load_o && !skip_o)
    else $error("dropped word had an effect");
  a_one_cycle_ops: assert property (
    dec_valid_o && instr_valid_i && dec_o.op inside {ADD_LITERAL_OP, LITERAL_SUBTRACT_OP,
    AND_LITERAL_OP, OR_LITERAL_OP, XOR_LITERAL_OP, LITERAL_MOVE_OP, LITERAL_MULTIPLY_OP,
    BANK_SELECT_LOAD_OP, STANDBY_OP, WATCHDOG_CLEAR_OP, STACK_PUSH_OP, STACK_POP_OP}
    |-> !pc_load_o ##1 !nop_cycle_o)
    else $error("one-cycle op took two");
  a_answer_next: assert property (dec_valid_o |-> $past(instr_valid_i))
    else $error("decode without fetched word");
  a_rd_one_cycle: assert property (reg_rdata_o != 8'h00 |-> $past(reg_rd_i))
    else $error("read data outside its cycle");
  c_skip: cover property (skip_o);
  c_call: cover property (pc_load_o && dec_o.op == ABS_CALL_OP);
  c_flush: cover property (nop_cycle_o);
  c_prescaler: cover property (prescaler_clr_o);
endmodule
bind mid_decoder mid_decoder_props mid_decoder_props_i (.mclk_i, .rst_i, .instr_i,
  .instr_valid_i, .status_i, .file_bit_i, .tst_file_o, .tst_bit_o, .dec_o, .dec_valid_o,
  .pc_load_o, .skip_o, .nop_cycle_o, .prescaler_clr_o, .reg_rd_i, .reg_rdata_o);

// >>> verif/mid_pmem.sv
// program memory model streaming instruction words
`timescale 1ns/100ps
module mid_pmem (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // stream control and words
  input wire logic go_i,
  output logic [15:0] instr_o,
  output logic valid_o
);
  logic [15:0] mem [0:7];
  int len = 0;
  int pc = 0;
  initial instr_o = 16'h0000;
  initial valid_o = 1'b0;
  // idle bus inverts every bit each cycle, so it repeats the last word on alternate cycles
  always @(posedge mclk_i) begin
    if (rst_i || !go_i || pc >= len) begin
      valid_o <= 1'b0;
      instr_o <= ~instr_o;
      if (!go_i) pc <= 0;
    end else begin
      instr_o <= mem[pc];
      valid_o <= 1'b1;
      pc <= pc + 1;
    end
  end
endmodule

// >>> verilog/mid_decoder.sv
// instruction decoder and sequencer for the 8-bit core
`timescale 1ns/100ps
module mid_decoder (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // instruction fetch
  input wire logic [mid_pkg::INSTR_W-1:0] instr_i,
  input wire logic instr_valid_i,
  // datapath status and tested bit
  input wire mid_pkg::mid_alu_s status_i,
  input wire logic file_bit_i,
  output logic [7:0] tst_file_o,
  output logic [2:0] tst_bit_o,
  // decoded command
  output mid_pkg::mid_dec_s dec_o,
  output logic dec_valid_o,
  output logic pc_load_o,
  output logic skip_o,
  output logic nop_cycle_o,
  output logic prescaler_clr_o,
  output logic pin_read_o,
  // register port
  input wire logic [mid_pkg::RA_W-1:0] reg_addr_i,
  input wire logic [mid_pkg::RD_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [mid_pkg::RD_W-1:0] reg_rdata_o
);
  import mid_pkg::*;

  // ****************************************
  // decode functions
  // ****************************************
  function automatic mid_op_e op_of(input logic [INSTR_W-1:0] w);
    logic [3:0] hi;
    logic [3:0] n2;
    logic [7:0] lo;
    mid_op_e op;
    hi = w[15:12];
    n2 = w[11:8];
    lo = w[7:0];
    op = BYTE_FILE_OP;
    case (hi)
      PFX_CLR: op = BIT_CLEAR_OP;
      PFX_SET: op = BIT_SET_OP;
      PFX_TGL: op = BIT_TOGGLE_OP;
      PFX_TSC: op = TEST_SKIP_CLEAR_OP;
      PFX_TSS: op = TEST_SKIP_SET_OP;
      // a lone partner word runs as a nop
      PFX_W2: op = NOP_OP;
      PFX_REL: op = w[11] ? RELATIVE_CALL_OP : BRANCH_ALWAYS_OP;
      // two-word ops are decided on the first word alone
      PFX_CTL: begin
        if (!n2[3]) begin
          op = BRANCH_COND_OP;
        end else if (n2[3:1] == N2_CALL) begin
          op = ABS_CALL_OP;
        end else if (n2 == N2_ABSOLUTE_JUMP_OP) begin
          op = ABSOLUTE_JUMP_OP;
        end else if (n2 == N2_PTR && w[7:6] == PTR_PAD) begin
          op = POINTER_LOAD_OP;
        end
      end
      PFX_LIT: begin
        case (n2)
          N2_ADD: op = ADD_LITERAL_OP;
          N2_SUB: op = LITERAL_SUBTRACT_OP;
          N2_AND: op = AND_LITERAL_OP;
          N2_IOR: op = OR_LITERAL_OP;
          N2_XOR: op = XOR_LITERAL_OP;
          N2_MOVLIT: op = LITERAL_MOVE_OP;
          N2_MUL: op = LITERAL_MULTIPLY_OP;
          N2_RETLIT: op = LITERAL_RETURN_OP;
          N2_BANK: begin
            if (w[7:4] == 4'h0) begin
              op = BANK_SELECT_LOAD_OP;
            end
          end
          N2_MISC: begin
            if (lo == LO_NOP) begin
              op = NOP_OP;
            end else if (lo == LO_SLEEP) begin
              op = STANDBY_OP;
            end else if (lo == LO_WDT) begin
              op = WATCHDOG_CLEAR_OP;
            end else if (lo == LO_PUSH) begin
              op = STACK_PUSH_OP;
            end else if (lo == LO_POP) begin
              op = STACK_POP_OP;
            end else if (lo == LO_DECADJ) begin
              op = DECIMAL_ADJUST_OP;
            end else if (lo == LO_SWRST) begin
              op = SOFT_RESET_OP;
            end else if (lo[7:1] == LO_IRET) begin
              op = INTERRUPT_RETURN_OP;
            end else if (lo[7:1] == LO_RET) begin
              op = SUB_RETURN_OP;
            end else if (lo[7:2] == LO_TABLE_READ_OP) begin
              op = TABLE_READ_OP;
            end else if (lo[7:2] == LO_TBLWR) begin
              op = TABLE_WRITE_OP;
            end
          end
          default: op = BYTE_FILE_OP;
        endcase
      end
      default: op = BYTE_FILE_OP;
    endcase
    return op;
  endfunction

  function automatic mid_flags_s flags_of(input mid_op_e op);
    mid_flags_s f;
    f = '0;
    case (op)
      ADD_LITERAL_OP, LITERAL_SUBTRACT_OP: f.alu = '1;
      AND_LITERAL_OP, OR_LITERAL_OP, XOR_LITERAL_OP: begin
        f.alu.zero = 1'b1;
        f.alu.negative = 1'b1;
      end
      STANDBY_OP, WATCHDOG_CLEAR_OP: begin
        f.timeout = 1'b1;
        f.powerdown = 1'b1;
      end
      // decimal adjust touches carry only
      DECIMAL_ADJUST_OP: f.alu.carry = 1'b1;
      default: f = '0;
    endcase
    return f;
  endfunction

  function automatic mid_dec_s dec_of(input logic [INSTR_W-1:0] w1,
                                      input logic [INSTR_W-1:0] w2);
    mid_dec_s d;
    d = '0;
    d.op = op_of(w1);
    d.lit = w1[7:0];
    // bank load keeps the low four bits only
    if (d.op == BANK_SELECT_LOAD_OP) begin
      d.lit = {4'h0, w1[3:0]};
    end
    d.file = w1[7:0];
    d.bitsel = w1[11:9];
    d.bank_acc = w1[8];
    d.fast = w1[0];
    if (d.op == ABS_CALL_OP) begin
      d.fast = w1[8];
    end
    d.tbl_mode = w1[1:0];
    d.ptr_sel = w1[5:4];
    d.ptr_lit = {w1[3:0], w2[7:0]};
    d.rel = d.op == BRANCH_COND_OP ? {{3{w1[7]}}, w1[7:0]} : w1[10:0];
    d.target = {w2[11:0], w1[7:0]};
    d.flags = flags_of(d.op);
    return d;
  endfunction

  // ****************************************
  // registers and state
  // ****************************************
  mid_state_e state;
  mid_state_e next_state;
  logic [INSTR_W-1:0] hold;
  logic [INSTR_W-1:0] next_hold;
  mid_dec_s next_dec;
  logic next_valid;
  logic next_pc;
  logic next_skip;
  logic next_nopc;
  logic next_psc;
  logic next_pin;
  logic [7:0] ctl;
  logic [7:0] tmr_addr;
  logic [7:0] port_lo;
  logic [7:0] port_hi;
  logic [RD_W-1:0] next_rdata;

  // ****************************************
  // fields of the word on the fetch bus
  // ****************************************
  // file and bit go out at once so the datapath
  // returns the tested bit within the same cycle
  wire [7:0] cur_file = instr_i[7:0];
  wire [2:0] cur_bit = instr_i[11:9];

  // ****************************************
  // decode of the current word
  // ****************************************
  wire mid_dec_s cur_dec = dec_of(instr_i, instr_i);
  wire mid_dec_s w2_dec = dec_of(hold, instr_i);
  wire mid_op_e cur_op = cur_dec.op;
  wire two_word = cur_op == ABS_CALL_OP || cur_op == ABSOLUTE_JUMP_OP
                  || cur_op == POINTER_LOAD_OP;
  wire w2_pc = w2_dec.op != POINTER_LOAD_OP;
  // branch condition
  wire [1:0] cc_sel = instr_i[10:9];
  wire cc_inv = instr_i[8];
  wire cc_raw = cc_sel == CC_ZERO ? status_i.zero :
                cc_sel == CC_CARRY ? status_i.carry :
                cc_sel == CC_OVF ? status_i.overflow : status_i.negative;
  wire br_taken = cur_op == BRANCH_COND_OP && (cc_raw ^ cc_inv);
  // bit test skip
  wire skip_hit = (cur_op == TEST_SKIP_CLEAR_OP && !file_bit_i)
                  || (cur_op == TEST_SKIP_SET_OP && file_bit_i);
  wire is_ret = cur_op == INTERRUPT_RETURN_OP || cur_op == SUB_RETURN_OP
                || cur_op == LITERAL_RETURN_OP;
  wire pc_chg = br_taken || is_ret || cur_op == BRANCH_ALWAYS_OP
                || cur_op == RELATIVE_CALL_OP;
  wire is_tbl = cur_op == TABLE_READ_OP || cur_op == TABLE_WRITE_OP;
  wire two_cyc = pc_chg || skip_hit || is_tbl;
  // file-modifying bit ops on special registers
  wire file_mod = cur_op == BIT_CLEAR_OP || cur_op == BIT_SET_OP
                  || cur_op == BIT_TOGGLE_OP;
  // access bit clear: the special-register bank
  wire acc_sfr = file_mod && !cur_dec.bank_acc;
  wire pin_hit = acc_sfr && cur_dec.file >= port_lo
                 && cur_dec.file <= port_hi;
  // prescaler clear only while it belongs to timer zero
  wire psc_hit = acc_sfr && cur_dec.file == tmr_addr
                 && ctl[CTL_PSA];

  assign tst_file_o = cur_file;
  assign tst_bit_o = cur_bit;

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    next_hold = hold;
    next_dec = dec_o;
    next_valid = 1'b0;
    next_pc = 1'b0;
    next_skip = 1'b0;
    next_nopc = 1'b0;
    next_psc = 1'b0;
    next_pin = 1'b0;
    case (state)
      ST_EXEC: begin
        // first of two words: park it for its partner
        if (instr_valid_i && two_word) begin
          next_hold = instr_i;
          next_state = ST_WORD2;
        end else if (instr_valid_i) begin
          next_valid = 1'b1;
          next_dec = cur_dec;
          next_pc = pc_chg;
          next_skip = skip_hit;
          next_psc = psc_hit;
          next_pin = pin_hit;
          if (two_cyc) begin
            next_state = ST_FLUSH;
          end
        end
      end
      // partner word completes the pending op
      ST_WORD2: begin
        if (instr_valid_i) begin
          next_valid = 1'b1;
          next_dec = w2_dec;
          next_pc = w2_pc;
          next_state = ST_EXEC;
        end
      end
      // word fetched behind a one-word pc change, a skip or a table op is spent as a nop
      ST_FLUSH: begin
        if (instr_valid_i) begin
          next_valid = 1'b1;
          next_dec = '0;
          next_nopc = 1'b1;
          next_state = ST_EXEC;
        end
      end
      default: next_state = ST_EXEC;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= ST_EXEC;
      hold <= '0;
      dec_o <= '0;
      dec_valid_o <= 1'b0;
      pc_load_o <= 1'b0;
      skip_o <= 1'b0;
      nop_cycle_o <= 1'b0;
      prescaler_clr_o <= 1'b0;
      pin_read_o <= 1'b0;
    end else begin
      state <= next_state;
      hold <= next_hold;
      dec_o <= next_dec;
      dec_valid_o <= next_valid;
      pc_load_o <= next_pc;
      skip_o <= next_skip;
      nop_cycle_o <= next_nopc;
      prescaler_clr_o <= next_psc;
      pin_read_o <= next_pin;
    end
  end

  // ****************************************
  // register port
  // ****************************************
  wire wr_ctl = reg_wr_i && reg_addr_i == REG_CTL;
  wire wr_tmr = reg_wr_i && reg_addr_i == REG_TMR_ADDR;
  wire wr_plo = reg_wr_i && reg_addr_i == REG_PORT_LO;
  wire wr_phi = reg_wr_i && reg_addr_i == REG_PORT_HI;
  // status: spare bit, sequencer state, last op
  wire [7:0] stat_word = {1'b0, state, dec_o.op};

  always_comb begin
    // unmapped: reads zero, writes dropped
    case (reg_addr_i)
      REG_CTL: next_rdata = ctl;
      REG_TMR_ADDR: next_rdata = tmr_addr;
      REG_PORT_LO: next_rdata = port_lo;
      REG_PORT_HI: next_rdata = port_hi;
      REG_STAT: next_rdata = stat_word;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctl <= CTL_RST;
      tmr_addr <= TMR_ADDR_RST;
      port_lo <= PORT_LO_RST;
      port_hi <= PORT_HI_RST;
      reg_rdata_o <= '0;
    end else begin
      if (wr_ctl) begin
        ctl <= reg_wdata_i;
      end
      if (wr_tmr) begin
        tmr_addr <= reg_wdata_i;
      end
      if (wr_plo) begin
        port_lo <= reg_wdata_i;
      end
      if (wr_phi) begin
        port_hi <= reg_wdata_i;
      end
      // read data stand one cycle, zero otherwise
      reg_rdata_o <= reg_rd_i ? next_rdata : '0;
    end
  end
endmodule
